//--- hdl/eca_top.sv
// Elliptic-curve accelerator core: two operand memories, microcode store,
// execution unit with a 32-bit ALU, host word port and control ports.
// Assumes host signals come from logic on clk_i, so no synchronisers.
`timescale 1ns/1ps
`default_nettype none
module eca_top #(
   parameter int MEM_WORDS = 528
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire eca_pkg::eca_hreq_t hreq_i,
   output eca_pkg::eca_hrsp_t hrsp_o,
   input wire logic start_i,
   input wire logic stop_i,
   input wire logic irq_en_i,
   input wire logic irq_ack_i,
   input wire logic [1:0] width_sel_i,
   input wire logic [7:0] partial_words_i,
   output logic busy_o,
   output logic done_o,
   output logic irq_o,
   output logic [3:0] pc_o
);
   localparam int AW = $clog2(MEM_WORDS);

   // Scratch slots 10..15 must fit behind the host-visible slots
   if (MEM_WORDS < (int'(eca_pkg::SCRATCH_SLOTS) + 1) * int'(eca_pkg::MAX_STRIDE_WORDS)) begin : g_chk
      $error("MEM_WORDS too small for sixteen slots of 33 words");
   end

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   function automatic logic [5:0] stride_words(input logic [1:0] sel);
      logic [7:0] b;
      b = eca_pkg::STRIDE_256;
      if (sel == eca_pkg::W512) begin
         b = eca_pkg::STRIDE_512;
      end else if (sel == eca_pkg::W1024) begin
         b = eca_pkg::STRIDE_1024;
      end
      return b[7:2];
   endfunction

   function automatic logic [AW-1:0] word_addr(input logic [1:0] sel,
      input logic [3:0] slot, input logic [5:0] word);
      logic [9:0] t;
      t = 10'(stride_words(sel)) * 10'(slot) + 10'(word);
      return AW'(t);
   endfunction

   // Length clamps to one word less than the slot stride when zero or too large
   function automatic logic [5:0] eff_len(input logic [1:0] sel,
      input logic [7:0] pw);
      logic [5:0] mx;
      mx = stride_words(sel) - 6'h01;
      if (pw == 8'h00 || pw > {2'h0, mx}) begin
         return mx;
      end
      return pw[5:0];
   endfunction

   // Program store; replace entries to add algorithms
   function automatic eca_pkg::eca_instr_t ucode(input logic [3:0] pc);
      unique case (pc)
         4'h0: ucode = {eca_pkg::OP_ADD, 4'h0, 4'h0, 1'b0, 4'hA};
         4'h1: ucode = {eca_pkg::OP_SUB, 4'hA, 4'h1, 1'b0, 4'hB};
         4'h2: ucode = {eca_pkg::OP_MOV, 4'hB, 4'h0, 1'b1, 4'h2};
         default: ucode = {eca_pkg::OP_END, 4'h0, 4'h0, 1'b0, 4'h0};
      endcase
   endfunction

   // ----------------------------------------
   // Operand memories
   // ----------------------------------------
   logic [31:0] mem_a [MEM_WORDS];
   logic [31:0] mem_b [MEM_WORDS];
   logic wa_en, wb_en;
   logic [AW-1:0] wa_addr, wb_addr;
   logic [31:0] wa_data, wb_data;

   // One writer per cycle: host only while idle, engine only while running
   always_ff @(posedge clk_i) begin
      if (wa_en) begin
         mem_a[wa_addr] <= wa_data;
      end
      if (wb_en) begin
         mem_b[wb_addr] <= wb_data;
      end
   end

   // ----------------------------------------
   // Engine state
   // ----------------------------------------
   eca_pkg::eca_state_t st_r, st_nxt;
   eca_pkg::eca_instr_t ins_r, ins_nxt;
   logic [3:0] pc_r, pc_nxt;
   logic [5:0] word_r, word_nxt, len_r, len_nxt;
   logic [1:0] sel_r, sel_nxt;
   logic carry_r, carry_nxt, done_r, done_nxt, irq_r, irq_nxt;
   logic busy_r, busy_nxt, done_set;
   logic [31:0] opa, opb, res;
   logic [32:0] sum;
   logic eng_we;
   logic [AW-1:0] eng_addr;

   always_comb begin
      st_nxt = st_r;
      ins_nxt = ins_r;
      pc_nxt = pc_r;
      word_nxt = word_r;
      len_nxt = len_r;
      sel_nxt = sel_r;
      carry_nxt = carry_r;
      done_set = 1'b0;
      eng_we = 1'b0;
      opa = mem_a[word_addr(sel_r, ins_r.sa, word_r)];
      opb = mem_b[word_addr(sel_r, ins_r.sb, word_r)];
      eng_addr = word_addr(sel_r, ins_r.ds, word_r);
      // Subtract as add of the inverted word with a seeded carry
      if (ins_r.op == eca_pkg::OP_SUB) begin
         opb = ~opb;
      end
      sum = {1'b0, opa} + {1'b0, opb} + {32'h0000_0000, carry_r};
      res = (ins_r.op == eca_pkg::OP_MOV) ? opa : sum[31:0];
      unique case (st_r)
         eca_pkg::ST_IDLE: begin
            if (start_i) begin
               sel_nxt = width_sel_i;
               len_nxt = eff_len(width_sel_i, partial_words_i);
               pc_nxt = 4'h0;
               st_nxt = eca_pkg::ST_FETCH;
            end
         end
         eca_pkg::ST_FETCH: begin
            ins_nxt = ucode(pc_r);
            pc_nxt = pc_r + 4'h1;
            word_nxt = 6'h00;
            carry_nxt = (ins_nxt.op == eca_pkg::OP_SUB);
            if (ins_nxt.op == eca_pkg::OP_END) begin
               st_nxt = eca_pkg::ST_IDLE;
               done_set = 1'b1;
            end else begin
               st_nxt = eca_pkg::ST_EXEC;
            end
         end
         eca_pkg::ST_EXEC: begin
            eng_we = 1'b1;
            carry_nxt = sum[32];
            word_nxt = word_r + 6'h01;
            if (word_r == len_r - 6'h01) begin
               st_nxt = eca_pkg::ST_FETCH;
            end
         end
      endcase
      if (stop_i && st_r != eca_pkg::ST_IDLE) begin
         st_nxt = eca_pkg::ST_IDLE;
         done_set = 1'b0;
      end
      // A completion in the acknowledge cycle is kept
      done_nxt = done_set | (done_r & ~irq_ack_i);
      irq_nxt = done_nxt & irq_en_i;
      busy_nxt = (st_nxt != eca_pkg::ST_IDLE);
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_r <= eca_pkg::ST_IDLE;
         ins_r <= '0;
         pc_r <= 4'h0;
         word_r <= 6'h00;
         len_r <= 6'h00;
         sel_r <= 2'h0;
         carry_r <= 1'b0;
         done_r <= 1'b0;
         irq_r <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         ins_r <= ins_nxt;
         pc_r <= pc_nxt;
         word_r <= word_nxt;
         len_r <= len_nxt;
         sel_r <= sel_nxt;
         carry_r <= carry_nxt;
         done_r <= done_nxt;
         irq_r <= irq_nxt;
         busy_r <= busy_nxt;
      end
   end

   // ----------------------------------------
   // Host port
   // ----------------------------------------
   eca_pkg::eca_hrsp_t rsp_r, rsp_nxt;
   logic hit_a, hit_b, ok, hwe;
   logic [12:0] off;
   logic [10:0] idx;
   logic [AW-1:0] hidx;

   always_comb begin
      hit_a = hreq_i.addr >= eca_pkg::RAM_A_BASE && hreq_i.addr < eca_pkg::RAM_B_BASE;
      hit_b = hreq_i.addr >= eca_pkg::RAM_B_BASE && hreq_i.addr < eca_pkg::WINDOW_END;
      off = hreq_i.addr - (hit_b ? eca_pkg::RAM_B_BASE : eca_pkg::RAM_A_BASE);
      idx = off[12:2];
      hidx = AW'(idx);
      // Scratch slots lie beyond slot 9 and stay hidden
      ok = (hit_a | hit_b) && hreq_i.addr[1:0] == 2'h0 && hreq_i.be == eca_pkg::FULL_BE
         && idx < eca_pkg::SLOT_COUNT * 11'(stride_words(width_sel_i));
      hwe = hreq_i.req && hreq_i.we && ok && st_r == eca_pkg::ST_IDLE;
      rsp_nxt.valid = hreq_i.req;
      rsp_nxt.err = hreq_i.req && (!ok || (hreq_i.we && st_r != eca_pkg::ST_IDLE));
      rsp_nxt.rdata = 32'h0000_0000;
      // Reads stay open during a run so partial results can be watched
      if (hreq_i.req && !hreq_i.we && ok) begin
         rsp_nxt.rdata = hit_b ? mem_b[hidx] : mem_a[hidx];
      end
      wa_en = hwe & hit_a;
      wb_en = hwe & hit_b;
      wa_addr = hidx;
      wb_addr = hidx;
      wa_data = hreq_i.wdata;
      wb_data = hreq_i.wdata;
      if (eng_we) begin
         wa_en = ~ins_r.db;
         wb_en = ins_r.db;
         wa_addr = eng_addr;
         wb_addr = eng_addr;
         wa_data = res;
         wb_data = res;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rsp_r <= '0;
      end else begin
         rsp_r <= rsp_nxt;
      end
   end

   assign hrsp_o = rsp_r;
   assign busy_o = busy_r;
   assign done_o = done_r;
   assign irq_o = irq_r;
   assign pc_o = pc_r;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_launch;
      start_i && st_r == eca_pkg::ST_IDLE ##1 busy_o;
   endsequence

   a_start_launch: assert property (start_i && st_r == eca_pkg::ST_IDLE |=> busy_o && pc_o == 4'h0)
      else $error("start did not launch next cycle");
   a_run_bounded: assert property (s_launch |-> ##[1:150] !busy_o)
      else $error("run did not finish in time");
   a_stop_halt: assert property (stop_i && busy_o && !done_o |=> !busy_o && !done_o)
      else $error("stop did not halt next cycle");
   a_irq_gate: assert property (!irq_en_i |=> !irq_o)
      else $error("interrupt high while disabled");
   a_done_hold: assert property (done_o && !irq_ack_i |=> done_o)
      else $error("done dropped without acknowledge");
   a_irq_follows: assert property (irq_en_i && done_set |=> irq_o && done_o)
      else $error("completion not signalled");
   a_busy_write: assert property (hreq_i.req && hreq_i.we && busy_o |=> hrsp_o.valid && hrsp_o.err)
      else $error("write during run not refused");
   a_byte_refuse: assert property (hreq_i.req && hreq_i.be != eca_pkg::FULL_BE |=> hrsp_o.err)
      else $error("partial word access accepted");
   a_slot_decode: assert property (hreq_i.req && hreq_i.addr == 13'h0484 && width_sel_i == eca_pkg::W1024
      && hreq_i.be == eca_pkg::FULL_BE && !hreq_i.we |=> !hrsp_o.err)
      else $error("slot one refused");
   a_window_end: assert property (hreq_i.req && hreq_i.addr >= eca_pkg::WINDOW_END |=> hrsp_o.err)
      else $error("access beyond window accepted");
endmodule
`default_nettype wire

//--- hdl/eca_pkg.sv
// Shared constants and types of the elliptic-curve accelerator core.
// Assumes a single system clock; the host reaches the operand memories
// through a simple word request port, control bits are plain ports.
package eca_pkg;
   // ----------------------------------------
   // Address window
   // ----------------------------------------
   localparam int ADDR_W = 13;
   localparam logic [12:0] WINDOW_END = 13'h1C00;
   localparam logic [12:0] RAM_A_BASE = 13'h0400;
   localparam logic [12:0] RAM_B_BASE = 13'h1000;
   localparam logic [3:0] FULL_BE = 4'hF;
   localparam logic [10:0] SLOT_COUNT = 11'h00A;
   localparam logic [7:0] STRIDE_256 = 8'h24;
   localparam logic [7:0] STRIDE_512 = 8'h44;
   localparam logic [7:0] STRIDE_1024 = 8'h84;
   localparam logic [3:0] SCRATCH_SLOTS = 4'hF;
   localparam logic [5:0] MAX_STRIDE_WORDS = 6'h21;

   // ----------------------------------------
   // Modes, opcodes, states
   // ----------------------------------------
   typedef enum logic [1:0] {
      W256 = 2'h0,
      W512 = 2'h1,
      W1024 = 2'h2
   } eca_width_t;
   localparam logic [1:0] OP_END = 2'h0;
   localparam logic [1:0] OP_ADD = 2'h1;
   localparam logic [1:0] OP_SUB = 2'h2;
   localparam logic [1:0] OP_MOV = 2'h3;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_FETCH = 3'h2,
      ST_EXEC = 3'h4
   } eca_state_t;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic [1:0] op;
      logic [3:0] sa;
      logic [3:0] sb;
      logic db;
      logic [3:0] ds;
   } eca_instr_t;
   typedef struct packed {
      logic req;
      logic we;
      logic [12:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } eca_hreq_t;
   typedef struct packed {
      logic valid;
      logic err;
      logic [31:0] rdata;
   } eca_hrsp_t;
endpackage

//--- bench/eca_host.sv
// Host master model for the accelerator word port.
// Assumes the bench calls its tasks; requests change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module eca_host (
   input wire logic clk_i,
   output eca_pkg::eca_hreq_t hreq_o,
   input wire eca_pkg::eca_hrsp_t hrsp_i
);
   initial hreq_o = '0;

   // ----------------------------------------
   // Word transfers
   // ----------------------------------------
   // Released fields are inverted so a stale address can never look valid
   task automatic xfer(input logic we, input logic [12:0] a, input logic [31:0] d, input logic [3:0] be,
                       output logic [1:0] ve, output logic [31:0] rd);
      @(negedge clk_i);
      hreq_o = '{req: 1'b1, we: we, addr: a, be: be, wdata: d};
      @(negedge clk_i);
      ve = {hrsp_i.valid, hrsp_i.err};
      rd = hrsp_i.rdata;
      hreq_o = '{req: 1'b0, we: ~we, addr: ~a, be: ~be, wdata: ~d};
   endtask

   // Two-word operand, low word first, whole words; caller keeps engine idle
   task automatic load(input logic [12:0] base, input logic [63:0] v);
      logic [1:0] ve;
      logic [31:0] rd;
      xfer(1'b1, base, v[31:0], eca_pkg::FULL_BE, ve, rd);
      xfer(1'b1, base + 13'h0004, v[63:32], eca_pkg::FULL_BE, ve, rd);
   endtask
endmodule
`default_nettype wire

//--- bench/eca_top_test.sv
// Self-checking bench for the accelerator core.
// Assumes eca_host drives the word port; control ports change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module eca_top_test;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic start_i = 1'b0;
   logic stop_i = 1'b0;
   logic irq_en_i = 1'b0;
   logic irq_ack_i = 1'b0;
   logic [1:0] width_sel_i = 2'h0;
   logic [7:0] partial_words_i = 8'h02;
   eca_pkg::eca_hreq_t hreq;
   eca_pkg::eca_hrsp_t hrsp;
   logic busy_o;
   logic done_o;
   logic irq_o;
   logic [3:0] pc_o;
   int bad_count = 0;
   int cmp_count = 0;
   int n;

   initial forever #25 clk_i = ~clk_i;

   eca_top #(.MEM_WORDS(528)) DUT (.clk_i(clk_i), .rstn_i(rstn_i), .hreq_i(hreq), .hrsp_o(hrsp),
      .start_i(start_i), .stop_i(stop_i), .irq_en_i(irq_en_i), .irq_ack_i(irq_ack_i),
      .width_sel_i(width_sel_i), .partial_words_i(partial_words_i), .busy_o(busy_o),
      .done_o(done_o), .irq_o(irq_o), .pc_o(pc_o));
   eca_host HOST (.clk_i(clk_i), .hreq_o(hreq), .hrsp_i(hrsp));

   // ----------------------------------------
   // Compare and report
   // ----------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      chk(what, {31'h0, exp}, {31'h0, got});
   endtask

   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // One access; refused or write answers carry zero data
   task automatic acc(input logic we, input logic [12:0] a, input logic [31:0] d, input logic [3:0] be,
                      input logic e);
      logic [1:0] ve;
      logic [31:0] rd;
      HOST.xfer(we, a, d, be, ve, rd);
      chk1("valid", 1'b1, ve[1]);
      chk1("err", e, ve[0]);
      chk("rdata", (we | e) ? 32'h0 : d, rd);
   endtask

   // Start pulse, then count falling edges until the engine drops busy
   task automatic run;
      @(negedge clk_i) start_i = 1'b1;
      @(negedge clk_i) start_i = 1'b0;
      chk1("busy after start", 1'b1, busy_o);
      chk("pc after start", 32'h0, {28'h0, pc_o});
      n = 1;
      while (busy_o === 1'b1 && n < 200) begin
         @(negedge clk_i);
         n++;
      end
      if (n >= 200) begin
         bad_count++;
         test_done();
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic map_check;
      logic [12:0] st;
      // Width code 3 falls back to the narrowest stride
      for (int s = 0; s < 4; s++) begin
         width_sel_i = s[1:0];
         st = {5'h0, (s == 0 || s == 3) ? eca_pkg::STRIDE_256 : (s == 1) ? eca_pkg::STRIDE_512 : eca_pkg::STRIDE_1024};
         acc(1'b1, eca_pkg::RAM_A_BASE + st, 32'hA5000000 + s, 4'hF, 1'b0);
         acc(1'b0, eca_pkg::RAM_A_BASE + st, 32'hA5000000 + s, 4'hF, 1'b0);
         acc(1'b1, eca_pkg::RAM_B_BASE + st * 13'h000A - 13'h0004, 32'h5B000000 + s, 4'hF, 1'b0);
         acc(1'b0, eca_pkg::RAM_B_BASE + st * 13'h000A - 13'h0004, 32'h5B000000 + s, 4'hF, 1'b0);
         acc(1'b0, eca_pkg::RAM_A_BASE + st * 13'h000A, 32'h0, 4'hF, 1'b1);
      end
      width_sel_i = 2'h0;
   endtask

   task automatic refuse_check;
      acc(1'b1, 13'h0400, 32'h1234ABCD, 4'hF, 1'b0);
      acc(1'b0, 13'h03FC, 32'h0, 4'hF, 1'b1);
      acc(1'b0, 13'h1C00, 32'h0, 4'hF, 1'b1);
      acc(1'b1, 13'h0402, 32'hFFFFFFFF, 4'hF, 1'b1);
      acc(1'b1, 13'h0400, 32'hFFFFFFFF, 4'h3, 1'b1);
      acc(1'b0, 13'h0400, 32'h1234ABCD, 4'hF, 1'b0);
   endtask

   // Two-word run: B2 = A0 + B0 - B1 with carry and borrow across words
   task automatic arith_check;
      HOST.load(13'h0400, 64'h00000001_FFFFFFFF);
      HOST.load(13'h1000, 64'h00000000_00000001);
      HOST.load(13'h1024, 64'h00000001_00000001);
      acc(1'b1, 13'h1050, 32'h5A5A5A5A, 4'hF, 1'b0);
      partial_words_i = 8'h02;
      irq_en_i = 1'b1;
      run();
      chk("run cycles", 32'(3 * (2 + 1) + 2), n);
      chk1("done", 1'b1, done_o);
      chk1("irq", 1'b1, irq_o);
      acc(1'b0, 13'h1048, 32'hFFFFFFFF, 4'hF, 1'b0);
      acc(1'b0, 13'h104C, 32'h00000000, 4'hF, 1'b0);
      acc(1'b0, 13'h1050, 32'h5A5A5A5A, 4'hF, 1'b0);
      chk1("irq held", 1'b1, irq_o);
      @(negedge clk_i) irq_ack_i = 1'b1;
      @(negedge clk_i) irq_ack_i = 1'b0;
      chk1("done acked", 1'b0, done_o);
      chk1("irq acked", 1'b0, irq_o);
   endtask

   task automatic mask_check;
      irq_en_i = 1'b0;
      // Six words on the narrow stride give a 192-bit operand
      partial_words_i = 8'h06;
      run();
      chk("run cycles 192", 32'(3 * (6 + 1) + 2), n);
      chk1("done masked", 1'b1, done_o);
      chk1("irq masked", 1'b0, irq_o);
      @(negedge clk_i) irq_en_i = 1'b1;
      repeat (2) @(negedge clk_i);
      chk1("irq unmasked", 1'b1, irq_o);
      @(negedge clk_i) irq_ack_i = 1'b1;
      @(negedge clk_i) irq_ack_i = 1'b0;
      chk1("done cleared", 1'b0, done_o);
   endtask

   // Long run interrupted: reads allowed, writes refused, stop takes one edge
   task automatic stop_check;
      partial_words_i = 8'h08;
      @(negedge clk_i) start_i = 1'b1;
      @(negedge clk_i) start_i = 1'b0;
      acc(1'b0, 13'h1000, 32'h00000001, 4'hF, 1'b0);
      acc(1'b1, 13'h1000, 32'hDEADBEEF, 4'hF, 1'b1);
      chk1("busy running", 1'b1, busy_o);
      @(negedge clk_i) stop_i = 1'b1;
      @(negedge clk_i) stop_i = 1'b0;
      chk1("busy stopped", 1'b0, busy_o);
      chk1("done stopped", 1'b0, done_o);
      acc(1'b0, 13'h1000, 32'h00000001, 4'hF, 1'b0);
   endtask

   initial begin
      repeat (3) @(negedge clk_i);
      rstn_i = 1'b1;
      chk1("busy reset", 1'b0, busy_o);
      chk1("done reset", 1'b0, done_o);
      map_check();
      refuse_check();
      arith_check();
      mask_check();
      stop_check();
      test_done();
   end
endmodule
`default_nettype wire
